// ### cpt_load_model.sv
// Load model: the gate-drive inputs hanging on the three timer pins.
// Assumes pull-ups on the load side, so an undriven pin reads high.
`timescale 1ns/10ps
`default_nettype none
module cpt_load_model
  import cpt_pkg::*;
(
  input  wire logic        core_clk,     // Core clock
  input  wire logic [7:0]  pinOut,       // Pin levels
  input  wire logic [7:0]  pinOe,        // Pin enables
  output logic             lineNormal,   // Normal-phase line
  output logic             lineToggle,   // Half-period line
  output logic             lineCounter,  // Counter-phase line
  output logic      [15:0] overlapCnt    // Cycles with both legs on
);
  // Only a pin set to output reaches the load; else the pull-up wins
  assign lineNormal  = pinOe[PIN_NORMAL] ? pinOut[PIN_NORMAL] : 1'b1;
  assign lineToggle  = pinOe[PIN_TOGGLE] ? pinOut[PIN_TOGGLE] : 1'b1;
  assign lineCounter = pinOe[PIN_COUNTER] ? pinOut[PIN_COUNTER] : 1'b1;
  initial overlapCnt = 16'h0000;
  // Both legs on at once would short the bridge
  always @(posedge core_clk) begin
    if (!lineNormal && !lineCounter) overlapCnt <= overlapCnt + 16'h0001;
  end
endmodule : cpt_load_model
`default_nettype wire

// ### cpt_pin_mux.sv
// Pin mux: merges timer outputs with plain port bits for the port pins.
// Assumes all inputs are registered on the same clock; output is registered.
`timescale 1ns/10ps
`default_nettype none
module cpt_pin_mux
  import cpt_pkg::*;
(
  input  wire logic       core_clk,   // Core clock
  input  wire logic       reset,      // Synchronous reset
  input  wire logic [7:0] portData,   // Port data register
  input  wire logic [7:0] portDir,    // Port direction register
  input  wire logic [7:0] pinSel,     // Pin select register
  input  wire logic       normalLvl,  // Normal-phase level
  input  wire logic       toggleLvl,  // Half-period toggle level
  input  wire logic       counterLvl, // Counter-phase level
  input  wire logic       timerOn,    // Timer active and in PWM mode
  output logic      [7:0] pinOut,     // Pin output level
  output logic      [7:0] pinOe       // Pin output enable
);
  logic [7:0] level_nxt;  // Combined level before register

  // Route each timer output to its pin when selected and active
  always_comb begin
    level_nxt = portData;
    if (timerOn && pinSel[PSEL_B_LSB +: 2] == PSEL_ASSIGNED) begin
      level_nxt[PIN_NORMAL] = normalLvl;
    end
    if (timerOn && pinSel[PSEL_C_LSB +: 2] == PSEL_ASSIGNED) begin
      level_nxt[PIN_TOGGLE] = toggleLvl;
    end
    if (timerOn && pinSel[PSEL_D_BIT]) begin
      level_nxt[PIN_COUNTER] = counterLvl;
    end
  end

  // Registered pins; direction bits alone decide drive
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pinOut <= BYTE_RST;
      pinOe  <= BYTE_RST;
    end else begin
      pinOut <= level_nxt;
      pinOe  <= portDir;
    end
  end
endmodule : cpt_pin_mux
`default_nettype wire

// ### cpt_pkg.sv
// Constants for the complementary PWM timer: register indices, field positions, resets.
// Assumes a byte-wide register port; each register index is a plain word address.
package cpt_pkg;
  // Register addresses (indices of our own choosing)
  localparam logic [4:0] ADDR_PORT_DATA  = 5'h00;
  localparam logic [4:0] ADDR_PORT_DIR   = 5'h01;
  localparam logic [4:0] ADDR_STANDBY    = 5'h02;
  localparam logic [4:0] ADDR_PIN_SEL    = 5'h03;
  localparam logic [4:0] ADDR_IRQ0       = 5'h04;
  localparam logic [4:0] ADDR_IRQ1       = 5'h05;
  localparam logic [4:0] ADDR_START      = 5'h06;
  localparam logic [4:0] ADDR_TRIG       = 5'h07;
  localparam logic [4:0] ADDR_MODE       = 5'h08;
  localparam logic [4:0] ADDR_FUNC       = 5'h09;
  localparam logic [4:0] ADDR_CTRL0      = 5'h0A;
  localparam logic [4:0] ADDR_CTRL1      = 5'h0B;
  localparam logic [4:0] ADDR_STATUS1    = 5'h0C;
  localparam logic [4:0] ADDR_CNT0_LO    = 5'h10;
  localparam logic [4:0] ADDR_CNT0_HI    = 5'h11;
  localparam logic [4:0] ADDR_CNT1_LO    = 5'h12;
  localparam logic [4:0] ADDR_CNT1_HI    = 5'h13;
  localparam logic [4:0] ADDR_GRA_LO     = 5'h14;
  localparam logic [4:0] ADDR_GRA_HI     = 5'h15;
  localparam logic [4:0] ADDR_GRB_LO     = 5'h16;
  localparam logic [4:0] ADDR_GRB_HI     = 5'h17;
  localparam logic [4:0] ADDR_GRC_LO     = 5'h18;
  localparam logic [4:0] ADDR_GRC_HI     = 5'h19;
  localparam logic [4:0] ADDR_GRD_LO     = 5'h1A;
  localparam logic [4:0] ADDR_GRD_HI     = 5'h1B;
  // Field positions
  localparam int STANDBY_BIT   = 4;
  localparam int RUN0_BIT      = 0;
  localparam int RUN1_BIT      = 1;
  localparam int CONT0_BIT     = 2;
  localparam int CONT1_BIT     = 3;
  localparam int TRIGA_BIT     = 0;
  localparam int TRIGB_BIT     = 1;
  localparam int SYNC_BIT      = 0;
  localparam int BUFC_BIT      = 4;
  localparam int BUFD_BIT      = 5;
  localparam int NORMAL_PHASE_LEVEL_SEL_BIT      = 2;
  localparam int COUNTER_PHASE_LEVEL_SEL_BIT      = 3;
  localparam int EXTCLK_BIT    = 6;
  localparam int IRQ_REQ_BIT   = 3;
  localparam int UDF_BIT       = 0;
  localparam int PSEL_B_LSB    = 2;
  localparam int PSEL_C_LSB    = 4;
  localparam int PSEL_D_BIT    = 6;
  // Encodings
  localparam logic [1:0] COMBO_COMPL   = 2'h2;
  localparam logic [2:0] SRC_F1        = 3'h0;
  localparam logic [2:0] IRQ_LVL_OFF   = 3'h0;
  localparam logic [1:0] PSEL_ASSIGNED = 2'h2;
  // Reset values
  localparam logic [7:0] STANDBY_RST   = 8'h10;
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam logic [15:0] WORD_RST     = 16'h0000;
  localparam logic [15:0] WORD_MAX     = 16'hFFFF;
  // Port pin positions of the three outputs
  localparam int PIN_TOGGLE    = 1;
  localparam int PIN_NORMAL    = 2;
  localparam int PIN_COUNTER   = 3;
endpackage : cpt_pkg

// ### cpt_timer.sv
// Complementary PWM timer: two counters, compare registers, buffer and pin outputs.
// Assumes a byte register port with one-cycle strobes and read data one cycle later.
`timescale 1ns/10ps
`default_nettype none
module cpt_timer
  import cpt_pkg::*;
#(
  parameter int CNT_W = 16  // Counter width
)
(
  input  wire logic       core_clk,     // Core clock, 20 MHz
  input  wire logic       reset,        // Synchronous reset, active high
  input  wire logic [4:0] regAddr,      // Register address
  input  wire logic [7:0] regWdata,     // Write data
  input  wire logic       regWr,        // Write strobe
  input  wire logic       regRd,        // Read strobe
  input  wire logic       extClk,       // External clock pin, unused in every mode
  output logic      [7:0] regRdata,     // Read data, cycle after strobe
  output logic      [7:0] pinOut,       // Port pin levels
  output logic      [7:0] pinOe,        // Port pin enables
  output logic            convTrigA,    // Conversion trigger A pulse
  output logic            convTrigB,    // Conversion trigger B pulse
  output logic            irq0,         // Counter zero interrupt request
  output logic            irq1          // Counter one interrupt request
);
  // Software registers
  logic [7:0]       portData_r;   // Port data
  logic [7:0]       portDir_r;    // Port direction
  logic [7:0]       standby_r;    // Module standby control
  logic [7:0]       pinSel_r;     // Pin select
  logic [2:0]       irqLvl0_r;    // Counter zero priority
  logic [2:0]       irqLvl1_r;    // Counter one priority
  logic             irqReq0_r;    // Counter zero request pending
  logic             irqReq1_r;    // Counter one request pending
  logic [3:0]       start_r;      // Run and continue bits
  logic [1:0]       trig_r;       // Trigger enables
  logic [7:0]       mode_r;       // Mode control
  logic [7:0]       func_r;       // Function control
  logic [7:0]       ctrl0_r;      // Counter zero control
  logic [7:0]       ctrl1_r;      // Counter one control
  logic             udf_r;        // Underflow flag
  logic [CNT_W-1:0] cnt0_r;       // Counter zero
  logic [CNT_W-1:0] cnt1_r;       // Counter one
  logic [CNT_W-1:0] gra_r;        // Period compare
  logic [CNT_W-1:0] grb_r;        // Change point
  logic [CNT_W-1:0] grc_r;        // General register C
  logic [CNT_W-1:0] grd_r;        // Change point buffer
  logic             down_r;       // Shared direction, 1 while counting down
  logic             normal_r;     // Normal-phase active flag
  logic             counter_r;    // Counter-phase active flag
  logic             toggle_r;     // Half-period toggle level
  logic             started_r;    // Counter-phase taken active at start

  // Decoded controls
  logic timerOn;     // Block out of standby
  logic complMode;   // Complementary PWM selected
  logic srcOk;       // Both sources are the undivided clock
  logic tick;        // Counting enabled this cycle
  logic matchA0;     // Counter zero hits register A
  logic matchB0;     // Counter zero hits register B
  logic matchB1;     // Counter one hits register B
  logic underflow;   // Counter one wraps going down
  logic wrCnt;       // Software write to any counter byte
  logic normalLvl;   // Normal-phase pin level
  logic counterLvl;  // Counter-phase pin level

  assign timerOn   = ~standby_r[STANDBY_BIT];
  assign complMode = func_r[1:0] == COMBO_COMPL;
  // Only the undivided clock is supported; other sources halt counting
  assign srcOk     = ctrl0_r[2:0] == SRC_F1 && ctrl1_r[2:0] == SRC_F1;
  // External clock select bit set also halts: no external counting here
  assign tick      = timerOn && complMode && srcOk && !func_r[EXTCLK_BIT]
                     && start_r[RUN0_BIT] && start_r[RUN1_BIT];
  assign matchA0   = !down_r && cnt0_r == gra_r;
  assign matchB0   = cnt0_r == grb_r;
  assign matchB1   = cnt1_r == grb_r;
  assign underflow = down_r && cnt1_r == WORD_RST[CNT_W-1:0];
  assign wrCnt     = regWr && regAddr >= ADDR_CNT0_LO && regAddr <= ADDR_CNT1_HI;

  // Register writes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      portData_r <= BYTE_RST;
      portDir_r  <= BYTE_RST;
      standby_r  <= STANDBY_RST;
      pinSel_r   <= BYTE_RST;
      irqLvl0_r  <= IRQ_LVL_OFF;
      irqLvl1_r  <= IRQ_LVL_OFF;
      trig_r     <= 2'h0;
      mode_r     <= BYTE_RST;
      func_r     <= BYTE_RST;
      ctrl0_r    <= BYTE_RST;
      ctrl1_r    <= BYTE_RST;
      gra_r      <= WORD_MAX[CNT_W-1:0];
      grc_r      <= WORD_MAX[CNT_W-1:0];
      grd_r      <= WORD_MAX[CNT_W-1:0];
    end else if (regWr) begin
      case (regAddr)
        ADDR_PORT_DATA: portData_r <= regWdata;
        ADDR_PORT_DIR:  portDir_r  <= regWdata;
        ADDR_STANDBY:   standby_r  <= regWdata;
        ADDR_PIN_SEL:   pinSel_r   <= regWdata;
        ADDR_IRQ0:      irqLvl0_r  <= regWdata[2:0]; // Request bit not writable
        ADDR_IRQ1:      irqLvl1_r  <= regWdata[2:0];
        ADDR_TRIG:      trig_r     <= regWdata[1:0];
        ADDR_MODE:      mode_r     <= regWdata;
        ADDR_FUNC:      func_r     <= regWdata;
        ADDR_CTRL0:     ctrl0_r    <= regWdata;
        ADDR_CTRL1:     ctrl1_r    <= regWdata;
        ADDR_GRA_LO:    gra_r[7:0]  <= regWdata;
        ADDR_GRA_HI:    gra_r[15:8] <= regWdata;
        ADDR_GRC_LO:    grc_r[7:0]  <= regWdata;
        ADDR_GRC_HI:    grc_r[15:8] <= regWdata;
        ADDR_GRD_LO:    grd_r[7:0]  <= regWdata;
        ADDR_GRD_HI:    grd_r[15:8] <= regWdata;
        default: ;
      endcase
    end
  end

  // Start register; the continue bits decide stop at the A match
  always_ff @(posedge core_clk) begin
    if (reset) begin
      start_r <= 4'h0;
    end else if (regWr && regAddr == ADDR_START) begin
      start_r <= regWdata[3:0];
    end else if (tick && matchA0) begin
      if (!start_r[CONT0_BIT]) start_r[RUN0_BIT] <= 1'b0;
      if (!start_r[CONT1_BIT]) start_r[RUN1_BIT] <= 1'b0;
    end
  end

  // Change point register: direct write, or buffer load at underflow only
  always_ff @(posedge core_clk) begin
    if (reset) begin
      grb_r <= WORD_MAX[CNT_W-1:0];
    end else if (tick && underflow && mode_r[BUFD_BIT]) begin
      grb_r <= grd_r;
    end else if (regWr && regAddr == ADDR_GRB_LO) begin
      grb_r[7:0] <= regWdata;
    end else if (regWr && regAddr == ADDR_GRB_HI) begin
      grb_r[15:8] <= regWdata;
    end
  end

  // Counters and shared direction; reset loads both with zero, software loads counter zero with the deadtime
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt0_r <= WORD_RST[CNT_W-1:0];
      cnt1_r <= WORD_RST[CNT_W-1:0];
      down_r <= 1'b0;
    end else if (wrCnt) begin
      // Each counter loads alone; no joint load with sync clear
      case (regAddr)
        ADDR_CNT0_LO: cnt0_r[7:0]  <= regWdata;
        ADDR_CNT0_HI: cnt0_r[15:8] <= regWdata;
        ADDR_CNT1_LO: cnt1_r[7:0]  <= regWdata;
        ADDR_CNT1_HI: cnt1_r[15:8] <= regWdata;
        default: ;
      endcase
      down_r <= 1'b0;
    end else if (tick) begin
      if (matchA0) begin
        down_r <= 1'b1;
        cnt0_r <= cnt0_r - 1'b1;
        cnt1_r <= cnt1_r - 1'b1;
      end else if (underflow) begin
        down_r <= 1'b0;
        // Wrap step still counts down, so the deadtime offset never drifts
        cnt0_r <= cnt0_r - 1'b1;
        cnt1_r <= WORD_MAX[CNT_W-1:0];
      end else if (down_r) begin
        cnt0_r <= cnt0_r - 1'b1;
        cnt1_r <= cnt1_r - 1'b1;
      end else begin
        cnt0_r <= cnt0_r + 1'b1;
        cnt1_r <= cnt1_r + 1'b1;
      end
    end
  end

  // Underflow flag: hardware set wins over software clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      udf_r <= 1'b0;
    end else if (tick && underflow) begin
      udf_r <= 1'b1;
    end else if (regWr && regAddr == ADDR_STATUS1 && !regWdata[UDF_BIT]) begin
      udf_r <= 1'b0;
    end
  end

  // Interrupt requests; level zero masks, pending clears on read of its control
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irqReq0_r <= 1'b0;
      irqReq1_r <= 1'b0;
    end else begin
      if (tick && matchA0 && irqLvl0_r != IRQ_LVL_OFF) begin
        irqReq0_r <= 1'b1;
      end else if (regRd && regAddr == ADDR_IRQ0) begin
        irqReq0_r <= 1'b0;
      end
      if (tick && underflow && irqLvl1_r != IRQ_LVL_OFF) begin
        irqReq1_r <= 1'b1;
      end else if (regRd && regAddr == ADDR_IRQ1) begin
        irqReq1_r <= 1'b0;
      end
    end
  end

  // Waveform flags: counter-phase active at start, normal set at B1 match going up, cleared at B1 match going down
  always_ff @(posedge core_clk) begin
    if (reset || !tick) begin
      normal_r  <= 1'b0;
      counter_r <= 1'b0;
      toggle_r  <= 1'b0;
      started_r <= 1'b0;
    end else begin
      started_r <= 1'b1;
      if (!started_r) begin
        counter_r <= 1'b1;
      end else if (matchB0) begin
        counter_r <= ~counter_r;
      end
      if (matchB1) begin
        normal_r <= ~down_r;
      end
      if (matchA0 || underflow) begin
        toggle_r <= ~toggle_r;
      end
    end
  end

  // Interlock guards overlap if software sets B outside its legal range
  // Level select zero: inactive high, active low
  assign normalLvl  = (normal_r && !counter_r) ^ ~func_r[NORMAL_PHASE_LEVEL_SEL_BIT];
  assign counterLvl = counter_r ^ ~func_r[COUNTER_PHASE_LEVEL_SEL_BIT];

  // Conversion triggers stay low unless enabled
  always_ff @(posedge core_clk) begin
    if (reset) begin
      convTrigA <= 1'b0;
      convTrigB <= 1'b0;
    end else begin
      convTrigA <= trig_r[TRIGA_BIT] && tick && matchA0;
      convTrigB <= trig_r[TRIGB_BIT] && tick && matchB0;
    end
  end

  // Outputs and read data
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq0     <= 1'b0;
      irq1     <= 1'b0;
      regRdata <= BYTE_RST;
    end else begin
      irq0 <= irqReq0_r;
      irq1 <= irqReq1_r;
      regRdata <= BYTE_RST;
      if (regRd) begin
        case (regAddr)
          ADDR_PORT_DATA: regRdata <= portData_r;
          ADDR_PORT_DIR:  regRdata <= portDir_r;
          ADDR_STANDBY:   regRdata <= standby_r;
          ADDR_PIN_SEL:   regRdata <= pinSel_r;
          ADDR_IRQ0:      regRdata <= {4'h0, irqReq0_r, irqLvl0_r};
          ADDR_IRQ1:      regRdata <= {4'h0, irqReq1_r, irqLvl1_r};
          ADDR_START:     regRdata <= {4'h0, start_r};
          ADDR_TRIG:      regRdata <= {6'h00, trig_r};
          ADDR_MODE:      regRdata <= mode_r;
          ADDR_FUNC:      regRdata <= func_r;
          ADDR_CTRL0:     regRdata <= ctrl0_r;
          ADDR_CTRL1:     regRdata <= ctrl1_r;
          ADDR_STATUS1:   regRdata <= {7'h00, udf_r};
          ADDR_CNT0_LO:   regRdata <= cnt0_r[7:0];
          ADDR_CNT0_HI:   regRdata <= cnt0_r[15:8];
          ADDR_CNT1_LO:   regRdata <= cnt1_r[7:0];
          ADDR_CNT1_HI:   regRdata <= cnt1_r[15:8];
          ADDR_GRA_LO:    regRdata <= gra_r[7:0];
          ADDR_GRA_HI:    regRdata <= gra_r[15:8];
          ADDR_GRB_LO:    regRdata <= grb_r[7:0];
          ADDR_GRB_HI:    regRdata <= grb_r[15:8];
          ADDR_GRC_LO:    regRdata <= grc_r[7:0];
          ADDR_GRC_HI:    regRdata <= grc_r[15:8];
          ADDR_GRD_LO:    regRdata <= grd_r[7:0];
          ADDR_GRD_HI:    regRdata <= grd_r[15:8];
          default:        regRdata <= BYTE_RST;
        endcase
      end
    end
  end

  // Pin routing and registered pin drive
  cpt_pin_mux u_pin_mux (
    .core_clk   (core_clk),
    .reset      (reset),
    .portData   (portData_r),
    .portDir    (portDir_r),
    .pinSel     (pinSel_r),
    .normalLvl  (normalLvl),
    .toggleLvl  (toggle_r),
    .counterLvl (counterLvl),
    .timerOn    (timerOn && complMode),
    .pinOut     (pinOut),
    .pinOe      (pinOe)
  );
endmodule : cpt_timer
`default_nettype wire

// ### cpt_timer_props.sv
// Checker: port-level properties of the complementary PWM timer.
// Assumes it is bound to cpt_timer and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module cpt_timer_props
  import cpt_pkg::*;
#(
  parameter int CNT_W = 16  // Counter width, kept for the bind
)
(
  input wire logic       core_clk,   // Core clock
  input wire logic       reset,      // Synchronous reset
  input wire logic [4:0] regAddr,    // Register address
  input wire logic [7:0] regWdata,   // Write data
  input wire logic       regWr,      // Write strobe
  input wire logic       regRd,      // Read strobe
  input wire logic       extClk,     // External clock pin
  input wire logic [7:0] regRdata,   // Read data
  input wire logic [7:0] pinOut,     // Pin levels
  input wire logic [7:0] pinOe,      // Pin enables
  input wire logic       convTrigA,  // Trigger A
  input wire logic       convTrigB,  // Trigger B
  input wire logic       irq0,       // Counter zero request
  input wire logic       irq1        // Counter one request
);
  logic [7:0] pselShadow_r;  // Shadow of pin select
  logic [1:0] trigShadow_r;  // Shadow of trigger enables
  logic [2:0] lvl0_r;        // Shadow of counter zero level
  logic [2:0] lvl1_r;        // Shadow of counter one level
  logic       dirWr;         // Direction write this cycle
  assign dirWr = regWr && (regAddr == ADDR_PORT_DIR);
  // Registers are invisible here, so mirror them from the write strobes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pselShadow_r <= 8'h00;
      trigShadow_r <= 2'h0;
      lvl0_r       <= 3'h0;
      lvl1_r       <= 3'h0;
    end else if (regWr) begin
      if (regAddr == ADDR_PIN_SEL) pselShadow_r <= regWdata;
      if (regAddr == ADDR_TRIG) trigShadow_r <= regWdata[1:0];
      if (regAddr == ADDR_IRQ0) lvl0_r <= regWdata[2:0];
      if (regAddr == ADDR_IRQ1) lvl1_r <= regWdata[2:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Read of counter zero interrupt control while its request stands
  sequence s_rdIrq0;
    regRd && (regAddr == ADDR_IRQ0) && irq0;
  endsequence
  // Both phases routed and driven: never both active low
  property p_noOverlap;
    (pselShadow_r[3:2] == PSEL_ASSIGNED) && pselShadow_r[PSEL_D_BIT] && pinOe[PIN_NORMAL]
      && pinOe[PIN_COUNTER] |-> (pinOut[PIN_NORMAL] || pinOut[PIN_COUNTER]);
  endproperty
  a_noOverlap: assert property (p_noOverlap) else $error("both phase outputs active");
  property p_trigAOff;
    (!trigShadow_r[TRIGA_BIT])[*3] |-> !convTrigA;
  endproperty
  a_trigAOff: assert property (p_trigAOff) else $error("trigger A while disabled");
  property p_trigBOff;
    (!trigShadow_r[TRIGB_BIT])[*3] |-> !convTrigB;
  endproperty
  a_trigBOff: assert property (p_trigBOff) else $error("trigger B while disabled");
  // Request can only rise if its level was nonzero when the flag set
  property p_irq0Lvl;
    $rose(irq0) |-> ($past(lvl0_r, 2) != IRQ_LVL_OFF);
  endproperty
  a_irq0Lvl: assert property (p_irq0Lvl) else $error("irq0 with level zero");
  property p_irq1Lvl;
    $rose(irq1) |-> ($past(lvl1_r, 2) != IRQ_LVL_OFF);
  endproperty
  a_irq1Lvl: assert property (p_irq1Lvl) else $error("irq1 with level zero");
  property p_irqClear;
    s_rdIrq0 |-> ##[1:3] !irq0;
  endproperty
  a_irqClear: assert property (p_irqClear) else $error("irq0 not cleared by read");
  property p_oeChange;
    $changed(pinOe) |-> ($past(dirWr, 1) || $past(dirWr, 2));
  endproperty
  a_oeChange: assert property (p_oeChange) else $error("pin enable moved alone");
  // Counter zero leaves the turning point at once, so one pulse only
  property p_trigPulse;
    convTrigA |=> !convTrigA;
  endproperty
  a_trigPulse: assert property (p_trigPulse) else $error("trigger A longer than one");
  property p_rdZero;
    !$past(regRd) |-> (regRdata == 8'h00);
  endproperty
  a_rdZero: assert property (p_rdZero) else $error("read data outside slot");
endmodule : cpt_timer_props
bind cpt_timer cpt_timer_props #(.CNT_W(CNT_W)) i_cpt_timer_props (
  .core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .extClk(extClk), .regRdata(regRdata), .pinOut(pinOut),
  .pinOe(pinOe), .convTrigA(convTrigA), .convTrigB(convTrigB), .irq0(irq0), .irq1(irq1));
`default_nettype wire

// ### test_complementary_pwm_timer.sv
// Testbench: configures the timer for complementary PWM and measures the pins.
// Assumes cpt_timer, cpt_load_model and the bound checker are compiled.
`timescale 1ns/10ps
`default_nettype none
module test_complementary_pwm_timer;
  import cpt_pkg::*;
  localparam logic [15:0] DEAD = 16'h0004;  // Dead time in cycles
  localparam logic [15:0] PER  = 16'h0028;  // Turning point
  localparam logic [15:0] CHG  = 16'h000F;  // First change point
  localparam logic [15:0] CHG2 = 16'h0019;  // Buffered change point
  localparam int PCYC  = (PER + 1 - DEAD) * 2;        // Cycles per period
  localparam int NLOW  = (PER - CHG - DEAD) * 2;      // Normal active
  localparam int CLOW  = (CHG + 1 - DEAD) * 2;        // Counter-phase active
  localparam int NLOW2 = (PER - CHG2 - DEAD) * 2;
  logic core_clk, reset, regWr, regRd, extClk, convTrigA, convTrigB, irq0, irq1;
  logic [4:0]  regAddr;      // Register address
  logic [7:0]  regWdata;     // Write data
  logic [7:0]  regRdata;     // Read data
  logic [7:0]  pinOut;       // Pin levels
  logic [7:0]  pinOe;        // Pin enables
  logic        lineNormal, lineToggle, lineCounter;
  logic [15:0] overlapCnt;   // Overlap cycles seen by the load
  logic [7:0]  d;            // Read byte
  logic [15:0] v, v2;        // Read words
  int err_total, n_tests, trigA, trigB, nl, cl, th, k;
  cpt_timer i_cpt_timer (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .extClk(extClk), .regRdata(regRdata),
    .pinOut(pinOut), .pinOe(pinOe), .convTrigA(convTrigA), .convTrigB(convTrigB),
    .irq0(irq0), .irq1(irq1));
  cpt_load_model i_cpt_load_model (.core_clk(core_clk), .pinOut(pinOut), .pinOe(pinOe),
    .lineNormal(lineNormal), .lineToggle(lineToggle), .lineCounter(lineCounter),
    .overlapCnt(overlapCnt));
  always #25 core_clk = ~core_clk;
  // Noise on the external clock pin, which must be ignored
  always @(posedge core_clk) extClk <= ~extClk;
  // Trigger pulses tallied per window
  always @(negedge core_clk) begin
    if (convTrigA === 1'b1) trigA++;
    if (convTrigB === 1'b1) trigB++;
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] x);
    @(posedge core_clk);
    regWr <= 1'b1; regAddr <= a; regWdata <= x;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [4:0] a, output logic [7:0] x);
    @(posedge core_clk);
    regRd <= 1'b1; regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    x = regRdata;
  endtask : rd
  task automatic wr16(input logic [4:0] a, input logic [15:0] x);
    wr(a, x[7:0]);
    wr(a + 5'h01, x[15:8]);
  endtask : wr16
  task automatic rd16(input logic [4:0] a, output logic [15:0] x);
    logic [7:0] lo, hi;
    rd(a, lo);
    rd(a + 5'h01, hi);
    x = {hi, lo};
  endtask : rd16
  // One full period: window phase does not change the totals
  task automatic meas();
    nl = 0; cl = 0; th = 0;
    repeat (PCYC) begin
      @(negedge core_clk);
      if (lineNormal === 1'b0) nl++;
      if (lineCounter === 1'b0) cl++;
      if (lineToggle === 1'b1) th++;
    end
  endtask : meas
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  // Run takes about 800 cycles; allow well beyond
  initial begin
    #(50 * 5000);
    err_total++;
    conclude();
  end
  initial begin
    core_clk = 0; reset = 1; regAddr = 5'h00; regWdata = 8'h00; regWr = 0; regRd = 0;
    extClk = 0; err_total = 0; n_tests = 0; trigA = 0; trigB = 0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    rd(ADDR_STANDBY, d); chk("standby", d, STANDBY_RST);
    rd(5'h1F, d); chk("unmapped", d, BYTE_RST);
    wr(ADDR_IRQ1, 8'h0F); rd(ADDR_IRQ1, d); chk("irq1 ctl", d & 8'h0F, 8'h07);
    wr(ADDR_IRQ1, 8'h00);
    wr(ADDR_PORT_DATA, 8'h0E); wr(ADDR_PORT_DIR, 8'h0E);
    wr(ADDR_STANDBY, 8'h00);
    wr(ADDR_PIN_SEL, 8'h68); wr(ADDR_IRQ0, 8'h07); wr(ADDR_START, 8'h0C);
    wr(ADDR_TRIG, 8'h00); wr(ADDR_MODE, 8'h20); wr(ADDR_FUNC, 8'h02);
    wr(ADDR_CTRL0, 8'h00); wr(ADDR_CTRL1, 8'h00);
    wr16(ADDR_CNT0_LO, DEAD); wr16(ADDR_CNT1_LO, 16'h0000);
    wr16(ADDR_GRA_LO, PER); wr16(ADDR_GRB_LO, CHG); wr16(ADDR_GRD_LO, CHG);
    chk("pin enables", {8'h00, pinOe}, 16'h000E);
    chk("idle levels", {lineNormal, lineCounter}, 2'b11);
    wr(ADDR_START, 8'h0F);
    repeat (2 * PCYC) @(posedge core_clk);
    trigA = 0;
    meas();
    chk("normal active", nl, NLOW);
    chk("counter active", cl, CLOW);
    chk("toggle high", th, PER - DEAD);
    chk("overlap", overlapCnt, 16'h0000);
    chk("trigger off", trigA, 0);
    rd(ADDR_STATUS1, d); chk("underflow", d & 8'h01, 8'h01);
    chk("irq1 idle", irq1, 1'b0);
    // Clear, then wait for the next turning point to fix the phase
    rd(ADDR_IRQ0, d);
    k = 0;
    @(negedge core_clk);
    while (irq0 !== 1'b1 && k < 200) begin
      @(negedge core_clk);
      k++;
    end
    chk("irq0 raised", irq0, 1'b1);
    rd(ADDR_IRQ0, d); chk("irq0 request", d[IRQ_REQ_BIT], 1'b1);
    repeat (3) @(posedge core_clk);
    chk("irq0 cleared", irq0, 1'b0);
    // Half a period from underflow: new point must wait for the boundary
    wr16(ADDR_GRD_LO, CHG2); rd16(ADDR_GRB_LO, v); chk("change held", v, CHG);
    repeat (2 * PCYC) @(posedge core_clk);
    rd16(ADDR_GRB_LO, v); chk("change loaded", v, CHG2);
    meas();
    chk("normal active 2", nl, NLOW2);
    wr(ADDR_TRIG, 8'h01);
    @(posedge core_clk);
    trigA = 0; trigB = 0;
    repeat (PCYC) @(posedge core_clk);
    chk("trigger A", trigA, 1);
    chk("trigger B off", trigB, 0);
    wr(ADDR_START, 8'h0C);
    rd16(ADDR_CNT1_LO, v);
    repeat (10) @(posedge core_clk);
    rd16(ADDR_CNT1_LO, v2); chk("stopped", v2, v);
    // Without continue bits the run flags drop at the next turning point
    wr(ADDR_START, 8'h03);
    repeat (PCYC + 2) @(posedge core_clk);
    rd(ADDR_START, d); chk("run cleared", d, 8'h00);
    conclude();
  end
endmodule : test_complementary_pwm_timer
`default_nettype wire
